// ---- gpiop_pkg.sv ----
// package for the gpio port block: register map, reset values, state layout
package gpiop_pkg;
	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0] GPIOP_OFF_P1_INPUT = 8'h00;
	localparam logic [7:0] GPIOP_OFF_P1_OUTPUT = 8'h04;
	localparam logic [7:0] GPIOP_OFF_P1_DIR = 8'h08;
	localparam logic [7:0] GPIOP_OFF_P1_PULL = 8'h0c;
	localparam logic [7:0] GPIOP_OFF_P1_EDGE = 8'h10;
	localparam logic [7:0] GPIOP_OFF_P1_IE = 8'h14;
	localparam logic [7:0] GPIOP_OFF_P1_IFG = 8'h18;
	localparam logic [7:0] GPIOP_OFF_P1_IV = 8'h1c;
	localparam logic [7:0] GPIOP_OFF_P2_INPUT = 8'h20;
	localparam logic [7:0] GPIOP_OFF_P2_OUTPUT = 8'h24;
	localparam logic [7:0] GPIOP_OFF_P2_DIR = 8'h28;
	localparam logic [7:0] GPIOP_OFF_P2_PULL = 8'h2c;
	localparam logic [7:0] GPIOP_OFF_P2_EDGE = 8'h30;
	localparam logic [7:0] GPIOP_OFF_P2_IE = 8'h34;
	localparam logic [7:0] GPIOP_OFF_P2_IFG = 8'h38;
	localparam logic [7:0] GPIOP_OFF_P2_IV = 8'h3c;
	localparam logic [7:0] GPIOP_OFF_IRQ_STATUS = 8'h40;
	localparam logic [7:0] GPIOP_OFF_IRQ_MASK = 8'h44;
	// ****************************************
	// reset values, vector step and port count
	// ****************************************
	localparam logic [7:0] GPIOP_RST_BYTE = 8'h00;
	localparam logic [15:0] GPIOP_RST_VEC = 16'h0000;
	localparam logic [1:0] GPIOP_RST_IRQ = 2'h0;
	localparam logic [15:0] GPIOP_VEC_STEP = 16'h0002;
	localparam int GPIOP_NUM_PORTS = 2;

	typedef struct packed {
		logic [7:0] input_levels;
		logic [7:0] output_levels;
		logic [7:0] direction;
		logic [7:0] pull_enable;
		logic [7:0] edge_select;
		logic [7:0] irq_enable;
		logic [7:0] irq_flags;
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:0] sync3;
	} gpiop_port_t;

	// pin-side signals of one port
	typedef struct packed {
		logic [7:0] out_level;
		logic [7:0] out_en_n;
		logic [7:0] pull_on;
		logic [7:0] pull_up;
	} gpiop_pins_t;

	typedef struct packed {
		gpiop_port_t [1:0] port;
		gpiop_pins_t [1:0] pins;
		logic [1:0] [15:0] vec;
		logic [1:0] port_req;
		logic [1:0] irq_status;
		logic [1:0] irq_mask;
		logic irq;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} gpiop_state_t;
endpackage

// ---- gpiop_top.sv ----
// gpio port pair with edge interrupts, apb slave
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/10ps
// Contract
// R1: a pin raises its port interrupt only when its enable bit is one
// R2: flags read one while pending; software writes may set or clear them
// R3: edge select one sets the flag on a falling input edge
// R4: edge select zero sets the flag on a rising input edge
// R5: input register returns synchronised pin levels; writes ignored
// R6: output pins drive the output register bit level
// R7: input pin with pull enabled: output bit zero pulls down, one pulls up
// R8: direction zero is input, one is output; resets to zero
// R9: pull resistor only on when enabled and pin is input
// R10: vector reads zero, or 2 to 16 for the lowest pending pin
// R11: port request is high while any enabled flag is set
module gpiop_top
	import gpiop_pkg::*;
(
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// port 1 pins
	input wire logic [7:0] p1_pin_in,
	output logic [7:0] p1_pin_out,
	output logic [7:0] p1_pin_oe_n,
	output logic [7:0] p1_pull_on,
	output logic [7:0] p1_pull_up,
	// port 2 pins
	input wire logic [7:0] p2_pin_in,
	output logic [7:0] p2_pin_out,
	output logic [7:0] p2_pin_oe_n,
	output logic [7:0] p2_pull_on,
	output logic [7:0] p2_pull_up,
	// interrupts
	output logic [1:0] port_irq,
	output logic irq
);
	// ****************************************
	// helpers
	// ****************************************
	// priority vector: pin 0 wins
	function automatic logic [15:0] gpiop_vector(input logic [7:0] pend);
		logic [15:0] v;
		v = GPIOP_RST_VEC;
		for (int i = 7; i >= 0; i--) begin
			if (pend[i]) begin
				v = 16'(GPIOP_VEC_STEP * (i + 1));
			end
		end
		return v;
	endfunction

	// each port owns a 32-byte window
	function automatic logic [7:0] gpiop_local(input logic [7:0] a);
		return {3'h0, a[4:0]};
	endfunction

	gpiop_state_t state_reg, state_next;
	logic wr_en, rd_en;
	logic [7:0] pin_in [2];
	logic [7:0] wbyte;
	logic wr_ok;

	assign pin_in[0] = p1_pin_in;
	assign pin_in[1] = p2_pin_in;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign wbyte = pwdata[7:0];
	// write lands on the edge that shows pready high; a refused transfer writes nothing
	assign wr_ok = wr_en && state_reg.pready && !state_reg.pslverr;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic [7:0] rise, fall, edges, pend;
		logic [1:0] req;
		logic [7:0] la;
		int sel;
		rise = 8'h00;
		fall = 8'h00;
		edges = 8'h00;
		pend = 8'h00;
		req = 2'h0;
		la = gpiop_local(paddr);
		sel = paddr[5] ? 1 : 0;
		state_next = state_reg;
		state_next.pready = 1'b0;
		state_next.pslverr = 1'b0;
		state_next.prdata = 32'h00000000;
		for (int p = 0; p < GPIOP_NUM_PORTS; p++) begin
			state_next.port[p].sync1 = pin_in[p];
			state_next.port[p].sync2 = state_reg.port[p].sync1;
			state_next.port[p].sync3 = state_reg.port[p].sync2;
			// R5: level taken once second and third stage agree
			for (int b = 0; b < 8; b++) begin
				if (state_reg.port[p].sync2[b] == state_reg.port[p].sync3[b]) begin
					state_next.port[p].input_levels[b] = state_reg.port[p].sync3[b];
				end
			end
			// R3 R4: edge detection chosen by edge select
			rise = state_next.port[p].input_levels & ~state_reg.port[p].input_levels;
			fall = ~state_next.port[p].input_levels & state_reg.port[p].input_levels;
			edges = (rise & ~state_reg.port[p].edge_select) | (fall & state_reg.port[p].edge_select);
			// R2: software write, then hardware set wins
			if (wr_ok && paddr[7:6] == 2'h0 && sel == p) begin
				case (la)
					GPIOP_OFF_P1_OUTPUT: state_next.port[p].output_levels = wbyte;
					GPIOP_OFF_P1_DIR: state_next.port[p].direction = wbyte;
					GPIOP_OFF_P1_PULL: state_next.port[p].pull_enable = wbyte;
					GPIOP_OFF_P1_EDGE: state_next.port[p].edge_select = wbyte;
					GPIOP_OFF_P1_IE: state_next.port[p].irq_enable = wbyte;
					GPIOP_OFF_P1_IFG: state_next.port[p].irq_flags = wbyte;
					default: ;
				endcase
			end
			state_next.port[p].irq_flags = state_next.port[p].irq_flags | edges;
			// R1 R11: enabled flags form the port request
			pend = state_next.port[p].irq_flags & state_next.port[p].irq_enable;
			req[p] = |pend;
			// R10: vector of lowest pending flag
			state_next.vec[p] = gpiop_vector(state_next.port[p].irq_flags);
			// R6 R8: driven when direction is one
			state_next.pins[p].out_level = state_next.port[p].output_levels;
			state_next.pins[p].out_en_n = ~state_next.port[p].direction;
			// R7 R9: pull only on input pins
			state_next.pins[p].pull_on = state_next.port[p].pull_enable & ~state_next.port[p].direction;
			state_next.pins[p].pull_up = state_next.port[p].output_levels;
		end
		// status: write one clears, new request wins
		if (wr_ok && paddr == GPIOP_OFF_IRQ_MASK) begin
			state_next.irq_mask = wbyte[1:0];
		end
		if (wr_ok && paddr == GPIOP_OFF_IRQ_STATUS) begin
			state_next.irq_status = state_reg.irq_status & ~wbyte[1:0];
		end
		state_next.irq_status = state_next.irq_status | req;
		state_next.irq = |(state_next.irq_status & state_next.irq_mask);
		state_next.port_req = req;
		// apb: one wait state, answer on second access cycle
		if (psel && penable && !state_reg.pready) begin
			state_next.pready = 1'b1;
			if (paddr[7:6] != 2'h0 && paddr != GPIOP_OFF_IRQ_STATUS && paddr != GPIOP_OFF_IRQ_MASK) begin
				state_next.pslverr = 1'b1;
			end else if (paddr[1:0] != 2'h0) begin
				state_next.pslverr = 1'b1;
			end
			if (rd_en) begin
				if (paddr == GPIOP_OFF_IRQ_STATUS) begin
					state_next.prdata = {30'h0, state_reg.irq_status};
				end else if (paddr == GPIOP_OFF_IRQ_MASK) begin
					state_next.prdata = {30'h0, state_reg.irq_mask};
				end else begin
					case (la)
						GPIOP_OFF_P1_INPUT: state_next.prdata = {24'h0, state_reg.port[sel].input_levels};
						GPIOP_OFF_P1_OUTPUT: state_next.prdata = {24'h0, state_reg.port[sel].output_levels};
						GPIOP_OFF_P1_DIR: state_next.prdata = {24'h0, state_reg.port[sel].direction};
						GPIOP_OFF_P1_PULL: state_next.prdata = {24'h0, state_reg.port[sel].pull_enable};
						GPIOP_OFF_P1_EDGE: state_next.prdata = {24'h0, state_reg.port[sel].edge_select};
						GPIOP_OFF_P1_IE: state_next.prdata = {24'h0, state_reg.port[sel].irq_enable};
						GPIOP_OFF_P1_IFG: state_next.prdata = {24'h0, state_reg.port[sel].irq_flags};
						GPIOP_OFF_P1_IV: state_next.prdata = {16'h0, state_reg.vec[sel]};
						default: state_next.prdata = 32'h00000000;
					endcase
				end
			end
		end
		if (state_next.pslverr) begin
			state_next.prdata = 32'h00000000;
		end
	end

	// ****************************************
	// registers
	// ****************************************
	// R8: direction and enables reset to zero; undefined registers also zeroed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
			for (int p = 0; p < GPIOP_NUM_PORTS; p++) begin
				state_reg.pins[p].out_en_n <= 8'hff;
			end
		end else begin
			state_reg <= state_next;
		end
	end

	assign prdata = state_reg.prdata;
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;
	assign p1_pin_out = state_reg.pins[0].out_level;
	assign p1_pin_oe_n = state_reg.pins[0].out_en_n;
	assign p1_pull_on = state_reg.pins[0].pull_on;
	assign p1_pull_up = state_reg.pins[0].pull_up;
	assign p2_pin_out = state_reg.pins[1].out_level;
	assign p2_pin_oe_n = state_reg.pins[1].out_en_n;
	assign p2_pull_on = state_reg.pins[1].pull_on;
	assign p2_pull_up = state_reg.pins[1].pull_up;
	assign irq = state_reg.irq;
	assign port_irq = state_reg.port_req;

	// ****************************************
	// checks
	// ****************************************
	AST_DIR_OE: assert property (@(posedge pclk) disable iff (!presetn) // R8
		p1_pin_oe_n == ~state_reg.port[0].direction) else $error("output enable mismatch");
	AST_OUT_LVL: assert property (@(posedge pclk) disable iff (!presetn) // R6
		p1_pin_out == state_reg.port[0].output_levels) else $error("pin level mismatch");
	AST_PULL_IN: assert property (@(posedge pclk) disable iff (!presetn) // R9
		(p1_pull_on & state_reg.port[0].direction) == 8'h00) else $error("pull on output pin");
	AST_PULL_SEL: assert property (@(posedge pclk) disable iff (!presetn) // R7
		p2_pull_up == state_reg.port[1].output_levels) else $error("pull select mismatch");
	AST_RISE: assert property (@(posedge pclk) disable iff (!presetn) // R4
		($rose(state_reg.port[0].input_levels[0]) && !$past(state_reg.port[0].edge_select[0]))
		|-> state_reg.port[0].irq_flags[0]) else $error("rising edge lost");
	AST_FALL: assert property (@(posedge pclk) disable iff (!presetn) // R3
		($fell(state_reg.port[0].input_levels[0]) && $past(state_reg.port[0].edge_select[0]))
		|-> state_reg.port[0].irq_flags[0]) else $error("falling edge lost");
	AST_ENABLE: assert property (@(posedge pclk) disable iff (!presetn) // R1
		(state_reg.port[0].irq_enable == 8'h00) |-> !port_irq[0]) else $error("masked pin raised request");
	AST_REQ: assert property (@(posedge pclk) disable iff (!presetn) // R11
		port_irq[1] |-> state_reg.irq_status[1]) else $error("status not set");
	AST_VEC0: assert property (@(posedge pclk) disable iff (!presetn) // R10
		state_reg.port[0].irq_flags[0] |-> state_reg.vec[0] == 16'h0002) else $error("vector priority wrong");
	AST_INPUT: assert property (@(posedge pclk) disable iff (!presetn) // R5
		(state_reg.port[0].sync2 == state_reg.port[0].sync3) |=> state_reg.port[0].input_levels ==
		$past(state_reg.port[0].sync3)) else $error("input level stale");
	AST_FLAGW: assert property (@(posedge pclk) disable iff (!presetn) // R2
		(wr_en && pready && !pslverr && paddr == GPIOP_OFF_P1_IFG) |=>
		(($past(pwdata[7:0]) & ~state_reg.port[0].irq_flags) == 8'h00)) else $error("flag write lost");

	// ****************************************
	// pin side checks, both ports
	// ****************************************
	AST_DIR_OE2: assert property (@(posedge pclk) disable iff (!presetn) // R8
		p2_pin_oe_n == ~state_reg.port[1].direction)
		else $error("output enable mismatch on port 2");
	AST_OUT_LVL2: assert property (@(posedge pclk) disable iff (!presetn) // R6
		p2_pin_out == state_reg.port[1].output_levels)
		else $error("pin level mismatch on port 2");
	AST_PULL_IN2: assert property (@(posedge pclk) disable iff (!presetn) // R9
		(p2_pull_on & state_reg.port[1].direction) == 8'h00)
		else $error("pull on output pin of port 2");
	AST_PULL_ON1: assert property (@(posedge pclk) disable iff (!presetn) // R9
		p1_pull_on == (state_reg.port[0].pull_enable & ~state_reg.port[0].direction))
		else $error("pull enable mismatch on port 1");
	AST_PULL_ON2: assert property (@(posedge pclk) disable iff (!presetn) // R9
		p2_pull_on == (state_reg.port[1].pull_enable & ~state_reg.port[1].direction))
		else $error("pull enable mismatch on port 2");
	AST_PULL_SEL1: assert property (@(posedge pclk) disable iff (!presetn) // R7
		p1_pull_up == state_reg.port[0].output_levels)
		else $error("pull select mismatch on port 1");
	AST_INPUT2: assert property (@(posedge pclk) disable iff (!presetn) // R5
		(state_reg.port[1].sync2 == state_reg.port[1].sync3) |=> state_reg.port[1].input_levels == $past(state_reg.port[1].sync3))
		else $error("input level stale on port 2");

	// ****************************************
	// interrupt checks
	// ****************************************
	AST_RISE2: assert property (@(posedge pclk) disable iff (!presetn) // R4
		($rose(state_reg.port[1].input_levels[7]) && !$past(state_reg.port[1].edge_select[7])) |-> state_reg.port[1].irq_flags[7])
		else $error("rising edge lost on port 2");
	AST_FALL2: assert property (@(posedge pclk) disable iff (!presetn) // R3
		($fell(state_reg.port[1].input_levels[0]) && $past(state_reg.port[1].edge_select[0])) |-> state_reg.port[1].irq_flags[0])
		else $error("falling edge lost on port 2");
	AST_ENABLE2: assert property (@(posedge pclk) disable iff (!presetn) // R1
		(state_reg.port[1].irq_enable == 8'h00) |-> !port_irq[1])
		else $error("masked pin raised request on port 2");
	AST_REQ_EQ0: assert property (@(posedge pclk) disable iff (!presetn) // R11
		port_irq[0] == |(state_reg.port[0].irq_flags & state_reg.port[0].irq_enable))
		else $error("port 1 request mismatch");
	AST_REQ_EQ1: assert property (@(posedge pclk) disable iff (!presetn) // R11
		port_irq[1] == |(state_reg.port[1].irq_flags & state_reg.port[1].irq_enable))
		else $error("port 2 request mismatch");
	AST_REQ0: assert property (@(posedge pclk) disable iff (!presetn) // R11
		port_irq[0] |-> state_reg.irq_status[0])
		else $error("status not set for port 1");
	AST_IRQ_MASK: assert property (@(posedge pclk) disable iff (!presetn) // R11
		irq == |(state_reg.irq_status & state_reg.irq_mask))
		else $error("interrupt line mismatch");
	AST_STICKY0: assert property (@(posedge pclk) disable iff (!presetn) // R11
		$fell(state_reg.irq_status[0]) |-> $past(wr_en))
		else $error("status 0 cleared without write");
	AST_STICKY1: assert property (@(posedge pclk) disable iff (!presetn) // R11
		$fell(state_reg.irq_status[1]) |-> $past(wr_en))
		else $error("status 1 cleared without write");
	// a flag only moves on an edge of its pin or on a software write
	AST_FLAG_SRC0: assert property (@(posedge pclk) disable iff (!presetn) // R2
		$rose(state_reg.port[0].irq_flags[0]) |-> ($past(wr_en) || $changed(state_reg.port[0].input_levels[0])))
		else $error("port 1 flag set without cause");
	AST_FLAG_SRC1: assert property (@(posedge pclk) disable iff (!presetn) // R2
		$rose(state_reg.port[1].irq_flags[7]) |-> ($past(wr_en) || $changed(state_reg.port[1].input_levels[7])))
		else $error("port 2 flag set without cause");
	AST_FLAG_HOLD0: assert property (@(posedge pclk) disable iff (!presetn) // R2
		$fell(state_reg.port[0].irq_flags[0]) |-> $past(wr_en))
		else $error("port 1 flag dropped without write");
	AST_FLAG_HOLD1: assert property (@(posedge pclk) disable iff (!presetn) // R2
		$fell(state_reg.port[1].irq_flags[0]) |-> $past(wr_en))
		else $error("port 2 flag dropped without write");
	AST_FLAGW2: assert property (@(posedge pclk) disable iff (!presetn) // R2
		(wr_en && pready && !pslverr && paddr == GPIOP_OFF_P2_IFG) |=>
		(($past(pwdata[7:0]) & ~state_reg.port[1].irq_flags) == 8'h00)) else $error("port 2 flag write lost");
	// vector: pin 0 first, value twice the pin number plus two
	AST_VEC_NONE0: assert property (@(posedge pclk) disable iff (!presetn) // R10
		(state_reg.port[0].irq_flags == 8'h00) |-> state_reg.vec[0] == 16'h0000)
		else $error("port 1 vector not zero");
	AST_VEC_NONE1: assert property (@(posedge pclk) disable iff (!presetn) // R10
		(state_reg.port[1].irq_flags == 8'h00) |-> state_reg.vec[1] == 16'h0000)
		else $error("port 2 vector not zero");
	AST_VEC_EVEN0: assert property (@(posedge pclk) disable iff (!presetn) // R10
		state_reg.vec[0][0] == 1'b0 && state_reg.vec[0] <= 16'h0010)
		else $error("port 1 vector out of range");
	AST_VEC_EVEN1: assert property (@(posedge pclk) disable iff (!presetn) // R10
		state_reg.vec[1][0] == 1'b0 && state_reg.vec[1] <= 16'h0010)
		else $error("port 2 vector out of range");
	AST_VEC_P0: assert property (@(posedge pclk) disable iff (!presetn) // R10
		state_reg.port[1].irq_flags[0] |-> state_reg.vec[1] == 16'h0002)
		else $error("port 2 vector pin 0 wrong");
	AST_VEC_P1: assert property (@(posedge pclk) disable iff (!presetn) // R10
		(state_reg.port[1].irq_flags[1:0] == 2'h2) |-> state_reg.vec[1] == 16'h0004)
		else $error("port 2 vector pin 1 wrong");
	AST_VEC_P2: assert property (@(posedge pclk) disable iff (!presetn) // R10
		(state_reg.port[1].irq_flags[2:0] == 3'h4) |-> state_reg.vec[1] == 16'h0006)
		else $error("port 2 vector pin 2 wrong");
	AST_VEC_P3: assert property (@(posedge pclk) disable iff (!presetn) // R10
		(state_reg.port[1].irq_flags[3:0] == 4'h8) |-> state_reg.vec[1] == 16'h0008)
		else $error("port 2 vector pin 3 wrong");
	AST_VEC_P4: assert property (@(posedge pclk) disable iff (!presetn) // R10
		(state_reg.port[1].irq_flags[4:0] == 5'h10) |-> state_reg.vec[1] == 16'h000a)
		else $error("port 2 vector pin 4 wrong");
	AST_VEC_P5: assert property (@(posedge pclk) disable iff (!presetn) // R10
		(state_reg.port[1].irq_flags[5:0] == 6'h20) |-> state_reg.vec[1] == 16'h000c)
		else $error("port 2 vector pin 5 wrong");
	AST_VEC_P6: assert property (@(posedge pclk) disable iff (!presetn) // R10
		(state_reg.port[1].irq_flags[6:0] == 7'h40) |-> state_reg.vec[1] == 16'h000e)
		else $error("port 2 vector pin 6 wrong");
	AST_VEC_P7: assert property (@(posedge pclk) disable iff (!presetn) // R10
		(state_reg.port[1].irq_flags == 8'h80) |-> state_reg.vec[1] == 16'h0010)
		else $error("port 2 vector pin 7 wrong");
endmodule

// ---- gpiop_pin_model.sv ----
// pin-side model of one port: outside drivers, pull resistors and the port's own drive
`timescale 1ns/10ps
module gpiop_pin_model (
	// from the port
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	input wire logic [7:0] pull_on,
	input wire logic [7:0] pull_up,
	// outside source
	input wire logic [7:0] ext_level,
	input wire logic [7:0] ext_drive,
	// to the port
	output logic [7:0] pin_in
);
	// port drive wins, then outside driver, then pull
	// a floating pin shows the inverse level so that no stale value passes
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_in[i] = !pin_oe_n[i] ? pin_out[i] : ext_drive[i] ? ext_level[i] : pull_on[i] ? pull_up[i] : ~ext_level[i];
		end
	end
endmodule

// ---- tb.sv ----
// testbench: apb register tests, pin drive, pulls and edge interrupts
`timescale 1ns/10ps
module tb;
	import gpiop_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [7:0] paddr, p1_in, p1_out, p1_oe_n, p1_pon, p1_pup, p2_in, p2_out, p2_oe_n, p2_pon, p2_pup;
	logic [7:0] ext1, drv1, ext2, drv2, base;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] port_irq;
	int errors, checks_done, cycles;

	gpiop_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.p1_pin_in(p1_in), .p1_pin_out(p1_out), .p1_pin_oe_n(p1_oe_n), .p1_pull_on(p1_pon), .p1_pull_up(p1_pup),
		.p2_pin_in(p2_in), .p2_pin_out(p2_out), .p2_pin_oe_n(p2_oe_n), .p2_pull_on(p2_pon), .p2_pull_up(p2_pup),
		.port_irq(port_irq), .irq(irq));
	gpiop_pin_model i_pins1 (.pin_out(p1_out), .pin_oe_n(p1_oe_n), .pull_on(p1_pon), .pull_up(p1_pup),
		.ext_level(ext1), .ext_drive(drv1), .pin_in(p1_in));
	gpiop_pin_model i_pins2 (.pin_out(p2_out), .pin_oe_n(p2_oe_n), .pull_on(p2_pon), .pull_up(p2_pup),
		.ext_level(ext2), .ext_drive(drv2), .pin_in(p2_in));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// the run needs a few hundred cycles; a hang stops here
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errors++;
			conclude();
		end
	end

	// ****************************************
	// bus and compare tasks
	// ****************************************
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		logic ok;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// look at the answer while it stands, before the edge that samples it
		do begin
			@(negedge pclk);
			ok = (pready === 1'b1);
			rd = prdata;
			err = pslverr;
			@(posedge pclk);
		end while (!ok);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk($sformatf("register %h", a), exp, rd);
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		cycles = 0;
		errors = 0;
		checks_done = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ext1 = 8'h00;
		drv1 = 8'hff;
		ext2 = 8'h00;
		drv2 = 8'hff;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("oe_n", 32'hffff, {16'h0, p2_oe_n, p1_oe_n});
		for (int p = 0; p < 2; p++) begin
			base = p ? 8'h20 : 8'h00;
			rchk(base + GPIOP_OFF_P1_DIR, 32'h0);
			rchk(base + GPIOP_OFF_P1_PULL, 32'h0);
			rchk(base + GPIOP_OFF_P1_IE, 32'h0);
			rchk(base + GPIOP_OFF_P1_IFG, 32'h0);
			rchk(base + GPIOP_OFF_P1_IV, 32'h0);
		end
		wr(GPIOP_OFF_P1_DIR, 32'hff);
		wr(GPIOP_OFF_P1_OUTPUT, 32'ha5);
		chk("pin_out", 32'ha5, {24'h0, p1_out});
		chk("oe_n", 32'h00, {24'h0, p1_oe_n});
		repeat (4) @(posedge pclk);
		rchk(GPIOP_OFF_P1_INPUT, 32'ha5);
		wr(GPIOP_OFF_P1_INPUT, 32'h00);
		rchk(GPIOP_OFF_P1_INPUT, 32'ha5);
		drv1 <= 8'h0f;
		wr(GPIOP_OFF_P1_DIR, 32'h0f);
		wr(GPIOP_OFF_P1_PULL, 32'hff);
		wr(GPIOP_OFF_P1_OUTPUT, 32'hf0);
		chk("pull_on", 32'hf0, {24'h0, p1_pon});
		chk("pull_up", 32'hf0, {24'h0, p1_pup});
		chk("oe_n", 32'hf0, {24'h0, p1_oe_n});
		repeat (4) @(posedge pclk);
		rchk(GPIOP_OFF_P1_INPUT, 32'hf0);
		rchk(GPIOP_OFF_P1_IFG, 32'hf5);
		rchk(GPIOP_OFF_P1_IV, 32'h02);
		wr(GPIOP_OFF_P1_IE, 32'h01);
		chk("port_irq", 32'h1, {30'h0, port_irq});
		wr(GPIOP_OFF_P1_IFG, 32'h00);
		rchk(GPIOP_OFF_P1_IFG, 32'h00);
		chk("port_irq", 32'h0, {30'h0, port_irq});
		wr(GPIOP_OFF_IRQ_STATUS, 32'h1);
		rchk(GPIOP_OFF_IRQ_STATUS, 32'h0);
		// edge flags on port 2: low nibble falling, high nibble rising
		wr(GPIOP_OFF_P2_EDGE, 32'h0f);
		wr(GPIOP_OFF_P2_IE, 32'hff);
		wr(GPIOP_OFF_IRQ_MASK, 32'h2);
		ext2 <= 8'hff;
		repeat (8) @(posedge pclk);
		rchk(GPIOP_OFF_P2_IFG, 32'hf0);
		rchk(GPIOP_OFF_P2_IV, 32'h0a);
		chk("port_irq", 32'h2, {30'h0, port_irq});
		chk("irq", 32'h1, {31'h0, irq});
		ext2 <= 8'h00;
		repeat (8) @(posedge pclk);
		rchk(GPIOP_OFF_P2_IFG, 32'hff);
		rchk(GPIOP_OFF_P2_IV, 32'h02);
		wr(GPIOP_OFF_P2_IE, 32'h00);
		chk("port_irq", 32'h0, {30'h0, port_irq});
		wr(GPIOP_OFF_IRQ_STATUS, 32'h2);
		rchk(GPIOP_OFF_IRQ_STATUS, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		wr(GPIOP_OFF_IRQ_MASK, 32'h0);
		wr(GPIOP_OFF_P2_IE, 32'h80);
		repeat (2) @(posedge pclk);
		rchk(GPIOP_OFF_IRQ_STATUS, 32'h2);
		chk("irq", 32'h0, {31'h0, irq});
		wr(GPIOP_OFF_P2_IFG, 32'h00);
		rchk(GPIOP_OFF_P2_IV, 32'h0);
		wr(GPIOP_OFF_P2_IFG, 32'h40);
		chk("port_irq", 32'h0, {30'h0, port_irq});
		wr(GPIOP_OFF_P2_IFG, 32'hc0);
		rchk(GPIOP_OFF_P2_IV, 32'h0e);
		chk("port_irq", 32'h2, {30'h0, port_irq});
		wr(GPIOP_OFF_IRQ_MASK, 32'h2);
		repeat (2) @(posedge pclk);
		chk("irq", 32'h1, {31'h0, irq});
		wr(8'h48, 32'hff);
		chk("write error", 32'h1, {31'h0, err});
		apb(1'b0, 8'h48, 32'h0);
		chk("read error", 32'h1, {31'h0, err});
		chk("read data", 32'h0, rd);
		conclude();
	end
endmodule
